// file: analog_monitor.sv
// analog monitor select and scale, two channels, AXI4-Lite register slave
// assumes source signals come from logic on the same clock; converter runs on
// the codes directly, +-10 V full scale
//
// How it works
// R1: two channels; each picks its source only from its own selector
// R2: speeds at 1 V per 1000 mm/s, forces at 1 V per rated force
// R3: code 03 gives position error at 0.05 V, zero outside position control
// R4: code 04 gives geared position error at 0.05 V per scale pulse
// R5: codes 08 and 0C give 5 V when their flag is true, else 0 V
// R6: code 0B gives 1 V for first gain set, 2 V for second
// R7: software never writes the reserved codes 06, 07 and 0D
// R8: output is minus the sum of signal times multiplier and offset
// R9: signed offset and multiplier per channel, clamped to +-10000, reset 0 and 100
// R10: result saturates at the 16-bit converter limits, never wraps
// R11: new settings reach the output on the next update without restart
`timescale 1ns/1ns
module analog_monitor
   import monitor_pkg::*;
(
   input wire logic aclk, // control clock, 100 MHz
   input wire logic aresetn, // synchronous reset, low
   input wire logic [monitor_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [monitor_pkg::ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic signed [31:0] motor_speed, // mm/s
   input wire logic signed [31:0] speed_ref, // mm/s
   input wire logic signed [31:0] pos_ref_speed, // mm/s
   input wire logic signed [31:0] speed_ff, // mm/s
   input wire logic signed [31:0] force_ref, // 0.1 % rated force
   input wire logic signed [31:0] force_ff, // 0.1 % rated force
   input wire logic signed [31:0] pos_err, // reference units
   input wire logic signed [31:0] amp_err, // scale pulses, after gearing
   input wire logic pos_mode, // high in position control
   input wire logic positioned, // positioning completed
   input wire logic ref_done, // position reference completed
   input wire logic gain2_active, // second gain set active
   output logic signed [15:0] mon1_code, // converter code, channel 1
   output logic signed [15:0] mon2_code // converter code, channel 2
);

   logic [15:0] sel1_reg, sel2_reg;
   code_t ofs1_reg, ofs2_reg, mul1_reg, mul2_reg;
   mv_t src_reg [N_SRC];
   logic aw_full_reg, w_full_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic aw_take, w_take, ar_take, do_write;
   logic aw_full_next, w_full_next, rvalid_next;
   logic [15:0] merged;
   code_t clamped;
   logic wr_hit;
   logic [31:0] rd_word;
   logic rd_hit;
   code_t ch_code [2];

   ////////////////////////////////////////////////////////////////////////////
   // write side: address and data are parked independently, either order
   always_comb begin
      aw_take = s_axi_awvalid && s_axi_awready;
      w_take = s_axi_wvalid && s_axi_wready;
      do_write = aw_full_reg && w_full_reg && !s_axi_bvalid;
      aw_full_next = (aw_full_reg && !do_write) || aw_take;
      w_full_next = (w_full_reg && !do_write) || w_take;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb_reg <= '0;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         s_axi_awready <= !aw_full_next;
         s_axi_wready <= !w_full_next;
         if (aw_take) begin
            awaddr_reg <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
      end
   end

   // byte merge then range clamp; out-of-range 16-bit values land on the nearest limit
   always_comb begin
      merged = 16'h0000;
      if (awaddr_reg == OFF_SEL1) begin
         merged = sel1_reg;
      end else if (awaddr_reg == OFF_SEL2) begin
         merged = sel2_reg;
      end else if (awaddr_reg == OFF_OFS1) begin
         merged = ofs1_reg;
      end else if (awaddr_reg == OFF_OFS2) begin
         merged = ofs2_reg;
      end else if (awaddr_reg == OFF_MUL1) begin
         merged = mul1_reg;
      end else if (awaddr_reg == OFF_MUL2) begin
         merged = mul2_reg;
      end
      if (wstrb_reg[0]) begin
         merged[7:0] = wdata_reg[7:0];
      end
      if (wstrb_reg[1]) begin
         merged[15:8] = wdata_reg[15:8];
      end
      if ($signed(merged) > PARAM_MAX) begin
         clamped = PARAM_MAX; // R9
      end else if ($signed(merged) < PARAM_MIN) begin
         clamped = PARAM_MIN; // R9
      end else begin
         clamped = $signed(merged);
      end
      wr_hit = (awaddr_reg == OFF_SEL1) || (awaddr_reg == OFF_SEL2) ||
               (awaddr_reg == OFF_OFS1) || (awaddr_reg == OFF_OFS2) ||
               (awaddr_reg == OFF_MUL1) || (awaddr_reg == OFF_MUL2) ||
               (awaddr_reg == OFF_STATUS);
   end

   // settings registers; they feed the channels with no restart needed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel1_reg <= SEL1_RST;
         sel2_reg <= SEL2_RST;
         ofs1_reg <= OFS_RST; // R9
         ofs2_reg <= OFS_RST; // R9
         mul1_reg <= MUL_RST; // R9
         mul2_reg <= MUL_RST; // R9
      end else if (do_write) begin
         if (awaddr_reg == OFF_SEL1) begin
            sel1_reg <= merged; // R11
         end else if (awaddr_reg == OFF_SEL2) begin
            sel2_reg <= merged; // R11
         end else if (awaddr_reg == OFF_OFS1) begin
            ofs1_reg <= clamped;
         end else if (awaddr_reg == OFF_OFS2) begin
            ofs2_reg <= clamped;
         end else if (awaddr_reg == OFF_MUL1) begin
            mul1_reg <= clamped;
         end else if (awaddr_reg == OFF_MUL2) begin
            mul2_reg <= clamped;
         end
      end
   end

   // write response; status writes are accepted and dropped
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read side: one outstanding read, answered the edge after the address
   always_comb begin
      ar_take = s_axi_arvalid && s_axi_arready;
      rvalid_next = (s_axi_rvalid && !s_axi_rready) || ar_take;
      rd_hit = 1'b1;
      rd_word = 32'h0000_0000;
      if (s_axi_araddr == OFF_SEL1) begin
         rd_word = {16'h0000, sel1_reg};
      end else if (s_axi_araddr == OFF_SEL2) begin
         rd_word = {16'h0000, sel2_reg};
      end else if (s_axi_araddr == OFF_OFS1) begin
         rd_word = {16'h0000, ofs1_reg};
      end else if (s_axi_araddr == OFF_OFS2) begin
         rd_word = {16'h0000, ofs2_reg};
      end else if (s_axi_araddr == OFF_MUL1) begin
         rd_word = {16'h0000, mul1_reg};
      end else if (s_axi_araddr == OFF_MUL2) begin
         rd_word = {16'h0000, mul2_reg};
      end else if (s_axi_araddr == OFF_STATUS) begin
         rd_word = {ch_code[1], ch_code[0]};
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !rvalid_next;
         s_axi_rvalid <= rvalid_next;
         if (ar_take) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // source table in millivolts; reserved entries stay at zero volts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < N_SRC; i++) begin
            src_reg[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N_SRC; i++) begin
            src_reg[i] <= '0;
         end
         src_reg[SEL_SPEED] <= motor_speed; // R2
         src_reg[SEL_SPEED_REF] <= speed_ref; // R2
         src_reg[SEL_POS_REF_SPEED] <= pos_ref_speed; // R2
         src_reg[SEL_SPEED_FF] <= speed_ff; // R2
         src_reg[SEL_FORCE_REF] <= force_ref; // R2
         src_reg[SEL_FORCE_FF] <= force_ff; // R2
         src_reg[SEL_POS_ERR] <= pos_mode ? 32'(pos_err * POS_ERR_MV) : '0; // R3
         src_reg[SEL_AMP_ERR] <= 32'(amp_err * POS_ERR_MV); // R4
         src_reg[SEL_POSITIONED] <= positioned ? FLAG_MV : '0; // R5
         src_reg[SEL_REF_DONE] <= ref_done ? FLAG_MV : '0; // R5
         src_reg[SEL_GAIN] <= gain2_active ? GAIN2_MV : GAIN1_MV; // R6
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the two channels; each sees only its own selector
   generate
      for (genvar c = 0; c < 2; c++) begin : g_ch
         chan_cfg_if cfg ();
         assign cfg.sel = (c == 0) ? sel1_reg[7:0] : sel2_reg[7:0]; // R1
         assign cfg.mult = (c == 0) ? mul1_reg : mul2_reg;
         assign cfg.offset = (c == 0) ? ofs1_reg : ofs2_reg;
         assign cfg.src = src_reg;
         assign ch_code[c] = cfg.code;
         monitor_channel u_chan (
            .aclk(aclk),
            .aresetn(aresetn),
            .cfg(cfg.chan)
         );
      end
   endgenerate

   // outputs come straight from the channel output flops
   assign mon1_code = ch_code[0];
   assign mon2_code = ch_code[1];

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence wr_sel1_s;
      do_write && awaddr_reg == OFF_SEL1 && wstrb_reg[1:0] == 2'h3;
   endsequence
   sequence wr_mul1_s;
      do_write && awaddr_reg == OFF_MUL1 && wstrb_reg[1:0] == 2'h3;
   endsequence

   cfg_write_a: assert property (wr_sel1_s |=> sel1_reg == $past(wdata_reg[15:0]) // R11
      ##4 g_ch[0].u_chan.sel_val_reg == $past(src_reg[sel1_reg[3:0]]) || sel1_reg[7:4] != 0)
      else $error("selector write not applied");
   clamp_range_a: assert property (wr_mul1_s |=> mul1_reg <= PARAM_MAX // R9
      && mul1_reg >= PARAM_MIN) else $error("multiplier outside range");
   // sampled reset guards the edge of release, when the table still holds reset zeros
   speed_map_a: assert property (aresetn |=> src_reg[SEL_SPEED] == $past(motor_speed)) // R2
      else $error("speed not mapped 1 mV per mm/s");
   force_map_a: assert property (aresetn |=> src_reg[SEL_FORCE_FF] == $past(force_ff)) // R2
      else $error("force feedforward not mapped");
   speed_ref_map_a: assert property (aresetn |=> // R2
      src_reg[SEL_SPEED_REF] == $past(speed_ref)) else $error("speed reference not mapped");
   pos_err_zero_a: assert property (!pos_mode |=> src_reg[SEL_POS_ERR] == 0) // R3
      else $error("position error not zero outside position control");
   pos_err_map_a: assert property (aresetn && pos_mode |=> // R3
      src_reg[SEL_POS_ERR] == 32'($past(pos_err) * 50))
      else $error("position error scale wrong");
   amp_err_a: assert property (aresetn |=> // R4
      src_reg[SEL_AMP_ERR] == 32'($past(amp_err) * 50))
      else $error("geared error scale wrong");
   flag_volt_a: assert property (((aresetn && positioned) ##1 1) |-> // R5
      src_reg[SEL_POSITIONED] == FLAG_MV
      && (!$past(ref_done) || src_reg[SEL_REF_DONE] == FLAG_MV))
      else $error("completion flag voltage wrong");
   ref_done_low_a: assert property (aresetn && !ref_done |=> // R5
      src_reg[SEL_REF_DONE] == 0) else $error("reference completion voltage wrong");
   gain_volt_a: assert property (aresetn && gain2_active |=> // R6
      src_reg[SEL_GAIN] == 32'sd2000) else $error("second gain level wrong");
   gain_low_a: assert property (aresetn && !gain2_active |=> // R6
      src_reg[SEL_GAIN] == 32'sd1000) else $error("first gain level wrong");

endmodule

// file: analog_monitor_select_scale_bench.sv
// self-checking bench for the analog monitor block
// assumes monitor_pkg, chan_cfg_if, monitor_channel, analog_monitor, scope_model
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
   checks_done++; \
   if ((got) !== (ex)) begin \
      failures++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
   end \
end
module analog_monitor_select_scale_bench;
   import monitor_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [4:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic signed [31:0] src [8];
   logic pos_mode, positioned, ref_done, gain2_active;
   logic signed [15:0] mon1, mon2, seen1, seen2, mul1, mul2, ofs1, ofs2;
   logic [7:0] s1, s2;
   logic [3:0] strb = 4'hF;
   int failures = 0;
   int checks_done = 0;
   int seed = 40008;
   // reserved codes 06, 07 and 0D are left out on purpose
   logic [7:0] codes [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08,
      8'h09, 8'h0A, 8'h0B, 8'h0C};
   logic [4:0] addrs [6] = '{OFF_SEL1, OFF_SEL2, OFF_OFS1, OFF_OFS2, OFF_MUL1, OFF_MUL2};
   logic [15:0] rsts [6] = '{SEL1_RST, SEL2_RST, OFS_RST, OFS_RST, MUL_RST, MUL_RST};

   always #5 aclk = ~aclk;

   analog_monitor i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .motor_speed(src[0]), .speed_ref(src[1]),
      .pos_ref_speed(src[2]), .speed_ff(src[3]), .force_ref(src[4]),
      .force_ff(src[5]), .pos_err(src[6]), .amp_err(src[7]), .pos_mode(pos_mode),
      .positioned(positioned), .ref_done(ref_done), .gain2_active(gain2_active),
      .mon1_code(mon1), .mon2_code(mon2));

   scope_model i_scope (.aclk(aclk), .mon1_code(mon1), .mon2_code(mon2),
      .seen1(seen1), .seen2(seen2));

   ////////////////////////////////////////////////////////////////////////////
   // expected converter code from selector, settings and current sources
   function automatic code_t exp_code(input logic [7:0] sel,
      input logic signed [15:0] mul, input logic signed [15:0] ofs);
      longint s;
      longint v;
      begin
         case (sel)
            8'h00: s = src[0];
            8'h01: s = src[1];
            8'h05: s = src[2];
            8'h09: s = src[3];
            8'h02: s = src[4];
            8'h0A: s = src[5];
            8'h03: s = pos_mode ? src[6] * 50 : 0;
            8'h04: s = src[7] * 50;
            8'h08: s = positioned ? 5000 : 0;
            8'h0B: s = gain2_active ? 2000 : 1000;
            8'h0C: s = ref_done ? 5000 : 0;
            default: s = 0;
         endcase
         v = -((((s * mul) + ofs * 10000) * 2147) >>> 16);
         // clip rather than wrap
         if (v > 32767) v = 32767;
         if (v < -32768) v = -32768;
         return v[15:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // verdict, reached from the end of the run and from any timeout
   task give_verdict;
      begin
         $display("mismatches %0d, comparisons %0d", failures, checks_done);
         if (failures == 0 && checks_done > 0) $display("bench passed");
         else $display("bench failed");
         $finish;
      end
   endtask

   // one write; each channel released only at the edge that takes it
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge aclk);
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
         do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
         end while (!(bvalid && bready) && n < 50);
         if (bvalid !== 1'b1) begin
            failures++;
            give_verdict();
         end
         resp = bresp;
         bready <= 1'b0;
      end
   endtask

   // one read, data taken at the edge that shows rvalid
   task automatic rd_reg(input logic [4:0] a);
      int n;
      begin
         n = 0;
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         rready <= 1'b1;
         do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
         end while (!(rvalid && rready) && n < 50);
         if (rvalid !== 1'b1) begin
            failures++;
            give_verdict();
         end
         rd = rdata;
         resp = rresp;
         rready <= 1'b0;
      end
   endtask

   // inputs held still, so the pipeline depth does not matter here
   task automatic check_out(input logic [7:0] a, input logic [7:0] b);
      begin
         repeat (8) @(posedge aclk);
         `CHK("mon1", exp_code(a, mul1, ofs1), seen1)
         `CHK("mon2", exp_code(b, mul2, ofs2), seen2)
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      {pos_mode, positioned, ref_done, gain2_active} = 4'h0;
      for (int i = 0; i < 8; i++) src[i] = 32'sd1000 + i;
      {mul1, mul2, ofs1, ofs2} = {MUL_RST, MUL_RST, OFS_RST, OFS_RST};
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      // register values after reset
      for (int i = 0; i < 6; i++) begin
         rd_reg(addrs[i]);
         `CHK("reset value", {16'h0000, rsts[i]}, rd)
         `CHK("read okay", RESP_OKAY, resp)
      end
      check_out(8'h02, 8'h00);
      // unmapped place answers with an error
      rd_reg(5'h1C);
      `CHK("unmapped read", RESP_DECERR, resp)
      wr(5'h1C, 32'h0000_1234);
      `CHK("unmapped write", RESP_DECERR, resp)
      // out-of-range settings are clipped to the accepted range
      wr(OFF_MUL1, 32'h0000_2EE0);
      `CHK("write okay", RESP_OKAY, resp)
      rd_reg(OFF_MUL1);
      `CHK("mult clip", {16'h0000, PARAM_MAX}, rd)
      wr(OFF_OFS2, 32'h0000_B1E0);
      rd_reg(OFF_OFS2);
      `CHK("offset clip", {16'h0000, PARAM_MIN}, rd)
      mul1 = PARAM_MAX;
      ofs2 = PARAM_MIN;
      // both ends of the converter range
      wr(OFF_SEL1, 32'h0000_0000);
      src[0] <= 32'sd30000;
      repeat (8) @(posedge aclk);
      `CHK("sat low", CODE_MIN, seen1)
      `CHK("sat high", CODE_MAX, seen2)
      rd_reg(OFF_STATUS);
      `CHK("status word", {CODE_MAX, CODE_MIN}, rd)
      // a one-byte write keeps the upper byte of the setting
      strb <= 4'h1;
      wr(OFF_OFS1, 32'h0000_7F05);
      strb <= 4'hF;
      rd_reg(OFF_OFS1);
      `CHK("byte write", 32'h0000_0005, rd)
      ofs1 = 16'sd5;
      // every legal code on both channels, random settings and sources
      for (int k = 0; k < 22; k++) begin
         s1 = codes[k % 11];
         s2 = codes[(k * 7 + 3) % 11];
         mul1 = $random(seed) % 300;
         mul2 = $random(seed) % 300;
         ofs1 = $random(seed) % 100;
         ofs2 = $random(seed) % 100;
         for (int i = 0; i < 8; i++) src[i] <= $random(seed) % 3000;
         {pos_mode, positioned, ref_done, gain2_active} <= 4'($random(seed));
         wr(OFF_SEL1, {24'h0, s1});
         wr(OFF_SEL2, {24'h0, s2});
         wr(OFF_MUL1, 32'(mul1));
         wr(OFF_MUL2, 32'(mul2));
         wr(OFF_OFS1, 32'(ofs1));
         wr(OFF_OFS2, 32'(ofs2));
         check_out(s1, s2);
      end
      // a second reset in mid-run brings every setting back
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd_reg(OFF_MUL2);
      `CHK("mid-run reset", {16'h0000, MUL_RST}, rd)
      {mul1, mul2, ofs1, ofs2} = {MUL_RST, MUL_RST, OFS_RST, OFS_RST};
      check_out(SEL1_RST[7:0], SEL2_RST[7:0]);
      give_verdict();
   end
endmodule

// file: chan_cfg_if.sv
// settings and source table handed from the register side to one channel
// assumes one instance per monitor channel, all on the same clock
`timescale 1ns/1ns
interface chan_cfg_if;
   import monitor_pkg::*;
   logic [7:0] sel;
   code_t mult;
   code_t offset;
   mv_t src [N_SRC];
   code_t code;
   modport ctrl (output sel, mult, offset, src, input code);
   modport chan (input sel, mult, offset, src, output code);
endinterface

// file: monitor_channel.sv
// one monitor channel: source pick, multiply, offset, negate, saturate
// assumes the source table and settings are registered by the caller
`timescale 1ns/1ns
module monitor_channel
   import monitor_pkg::*;
(
   input wire logic aclk, // control clock
   input wire logic aresetn, // synchronous reset, low
   chan_cfg_if.chan cfg // settings in, code out
);

   mv_t sel_val_reg;
   code_t mult_reg;
   code_t ofs_reg;
   logic signed [63:0] sum_reg;
   code_t code_reg;
   logic signed [63:0] scaled;

   ////////////////////////////////////////////////////////////////////////////
   // stage 1: pick the source; any code with a set upper nibble reads zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sel_val_reg <= '0;
         mult_reg <= MUL_RST;
         ofs_reg <= OFS_RST;
      end else begin
         sel_val_reg <= (cfg.sel[7:4] == 4'h0) ? cfg.src[cfg.sel[3:0]] : '0; // R1
         mult_reg <= cfg.mult; // R11
         ofs_reg <= cfg.offset; // R11
      end
   end

   // stage 2: signal times multiplier plus offset, in 0.01 mV
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sum_reg <= '0;
      end else begin
         sum_reg <= 64'(sel_val_reg) * 64'(mult_reg) + 64'(ofs_reg) * 64'(OFS_WEIGHT); // R8
      end
   end

   // stage 3: sign inversion and clamp so a large value never wraps
   always_comb begin
      scaled = -((sum_reg * 64'(DAC_K)) >>> DAC_SHIFT); // R8
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         code_reg <= '0;
      end else if (scaled > 64'(CODE_MAX)) begin
         code_reg <= CODE_MAX; // R10
      end else if (scaled < 64'(CODE_MIN)) begin
         code_reg <= CODE_MIN; // R10
      end else begin
         code_reg <= scaled[15:0];
      end
   end

   assign cfg.code = code_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   chan_select_a: assert property ((cfg.sel[7:4] == 4'h0) |=> // R1
      sel_val_reg == $past(cfg.src[cfg.sel[3:0]])) else $error("wrong source picked");
   sum_form_a: assert property (##1 sum_reg == // R8
      64'($past(sel_val_reg)) * 64'($past(mult_reg)) + 64'($past(ofs_reg)) * 64'(OFS_WEIGHT))
      else $error("sum does not follow signal and offset");
   negate_a: assert property ((sum_reg > 64'sd1000 && sum_reg < 64'sd1000000) |=> // R8
      code_reg < 0) else $error("positive sum not inverted");
   sat_high_a: assert property ((sum_reg > 64'sd100000000) |=> // R10
      code_reg == CODE_MIN) else $error("overflow not saturated");

endmodule

// file: monitor_pkg.sv
// constants, offsets and types shared by the analog monitor block
// assumes a 100 MHz control clock and a 16-bit bipolar converter behind the outputs
package monitor_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register map, byte addresses on the register bus
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFF_SEL1 = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_SEL2 = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_OFS1 = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_OFS2 = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_MUL1 = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_MUL2 = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h18;

   // values after reset
   localparam logic [15:0] SEL1_RST = 16'h0002;
   localparam logic [15:0] SEL2_RST = 16'h0000;
   localparam logic [15:0] OFS_RST = 16'h0000;
   localparam logic [15:0] MUL_RST = 16'h0064;

   // accepted parameter range, both ends inclusive
   localparam logic signed [15:0] PARAM_MAX = 16'sh2710;
   localparam logic signed [15:0] PARAM_MIN = 16'shD8F0;

   // response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // selector codes, low byte of a selector register
   localparam logic [3:0] SEL_SPEED = 4'h0;
   localparam logic [3:0] SEL_SPEED_REF = 4'h1;
   localparam logic [3:0] SEL_FORCE_REF = 4'h2;
   localparam logic [3:0] SEL_POS_ERR = 4'h3;
   localparam logic [3:0] SEL_AMP_ERR = 4'h4;
   localparam logic [3:0] SEL_POS_REF_SPEED = 4'h5;
   localparam logic [3:0] SEL_POSITIONED = 4'h8;
   localparam logic [3:0] SEL_SPEED_FF = 4'h9;
   localparam logic [3:0] SEL_FORCE_FF = 4'hA;
   localparam logic [3:0] SEL_GAIN = 4'hB;
   localparam logic [3:0] SEL_REF_DONE = 4'hC;
   localparam int N_SRC = 16;

   ////////////////////////////////////////////////////////////////////////////
   // scaling, every source is expressed in millivolts before the multiplier
   localparam logic signed [31:0] POS_ERR_MV = 32'sh0000_0032;
   localparam logic signed [31:0] FLAG_MV = 32'sh0000_1388;
   localparam logic signed [31:0] GAIN1_MV = 32'sh0000_03E8;
   localparam logic signed [31:0] GAIN2_MV = 32'sh0000_07D0;
   // offset step 0.1 V against product unit 0.01 mV
   localparam logic signed [31:0] OFS_WEIGHT = 32'sh0000_2710;
   // 0.01 mV to converter code for +-10 V full scale: 2^31/1e6, 16 fraction bits
   localparam logic signed [15:0] DAC_K = 16'sh0863;
   localparam int DAC_SHIFT = 16;
   localparam logic signed [15:0] CODE_MAX = 16'sh7FFF;
   localparam logic signed [15:0] CODE_MIN = 16'sh8000;

   typedef logic signed [31:0] mv_t;
   typedef logic signed [15:0] code_t;

endpackage

// file: scope_model.sv
// measuring instrument model: samples both converter codes on every clock
// assumes the codes change only on rising edges of aclk
`timescale 1ns/1ns
module scope_model (
   input wire logic aclk, // control clock
   input wire logic signed [15:0] mon1_code, // channel 1 code
   input wire logic signed [15:0] mon2_code, // channel 2 code
   output logic signed [15:0] seen1, // last sample, channel 1
   output logic signed [15:0] seen2 // last sample, channel 2
);
   // a recorder only listens; it never loads or drives the outputs back
   always_ff @(posedge aclk) begin
      seen1 <= mon1_code;
      seen2 <= mon2_code;
   end
endmodule
